/* File: src/tmr_count_unit.sv */
// one timer/counter: low and high count bytes with the four modes
`timescale 1ns/1ps
`include "tmr_defs.svh"
module tmr_count_unit
    import tmr_pkg::*;
#(
    parameter int CNT_W = 8
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // mode and count events
    input wire tmr_mode_t mode_i,
    input wire logic lo_inc_i,
    input wire logic hi_inc_i,
    // software writes
    input wire logic lo_wr_i,
    input wire logic hi_wr_i,
    input wire tmr_byte_t wdata_i,
    // count bytes and overflow pulses
    output tmr_byte_t lo_o,
    output tmr_byte_t hi_o,
    output logic lo_ovf_o,
    output logic hi_ovf_o
);
    tmr_byte_t lo_q, hi_q, lo_d, hi_d;

    generate
        if (CNT_W != 8) begin : g_chk
            $error("tmr_count_unit serves byte wide counts only");
        end
    endgenerate

    // next count per mode; a software write beats the increment
    always_comb begin
        lo_d = lo_q;
        hi_d = hi_q;
        lo_ovf_o = 1'b0;
        hi_ovf_o = 1'b0;
        unique case (mode_i)
            `TMR_MODE_13BIT: begin
                if (lo_inc_i) begin
                    // upper three low bits are left alone
                    lo_d[`TMR_PRE_MSB:0] = lo_q[`TMR_PRE_MSB:0] + `TMR_PRE_ONE; // R19
                    if (lo_q[`TMR_PRE_MSB:0] == `TMR_PRE_MAX) begin
                        hi_d = hi_q + `TMR_BYTE_ONE;
                        lo_ovf_o = (hi_q == `TMR_BYTE_MAX);
                    end
                end
            end
            `TMR_MODE_16BIT: begin
                if (lo_inc_i) begin
                    lo_d = lo_q + `TMR_BYTE_ONE; // R11
                    if (lo_q == `TMR_BYTE_MAX) begin
                        hi_d = hi_q + `TMR_BYTE_ONE;
                        lo_ovf_o = (hi_q == `TMR_BYTE_MAX);
                    end
                end
            end
            `TMR_MODE_RELOAD: begin
                if (lo_inc_i) begin
                    if (lo_q == `TMR_BYTE_MAX) begin
                        lo_d = hi_q; // R16
                        lo_ovf_o = 1'b1;
                    end else begin
                        lo_d = lo_q + `TMR_BYTE_ONE;
                    end
                end
            end
            `TMR_MODE_SPLIT: begin
                if (lo_inc_i) begin
                    lo_d = lo_q + `TMR_BYTE_ONE; // R16
                    lo_ovf_o = (lo_q == `TMR_BYTE_MAX);
                end
                if (hi_inc_i) begin
                    hi_d = hi_q + `TMR_BYTE_ONE;
                    hi_ovf_o = (hi_q == `TMR_BYTE_MAX);
                end
            end
        endcase
        if (lo_wr_i) begin
            lo_d = wdata_i; // R20
        end
        if (hi_wr_i) begin
            hi_d = wdata_i; // R20
        end
    end

    // count bytes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lo_q <= `TMR_CNT_RST; // R12
            hi_q <= `TMR_CNT_RST;
        end else begin
            lo_q <= lo_d;
            hi_q <= hi_d;
        end
    end

    assign lo_o = lo_q;
    assign hi_o = hi_q;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_reload_from_hi: assert property ( // R16
        mode_i == `TMR_MODE_RELOAD && lo_inc_i && lo_q == `TMR_BYTE_MAX && !lo_wr_i && !hi_wr_i
        |=> lo_q == $past(hi_q) && $stable(hi_q))
        else $error("reload did not copy the high byte");
endmodule

/* File: src/tmr_defs.svh */
// register addresses, bit positions, reset values and mode codes of the timer block
`ifndef TMR_DEFS_SVH
`define TMR_DEFS_SVH
// register addresses on the special function register port
`define TMR_ADDR_CTRL 8'h88
`define TMR_ADDR_T0_LO 8'h8a
`define TMR_ADDR_T1_LO 8'h8b
`define TMR_ADDR_T0_HI 8'h8c
`define TMR_ADDR_T1_HI 8'h8d
`define TMR_RDATA_NONE 8'h00
// reset values
`define TMR_CTRL_RST 8'h00
`define TMR_CNT_RST 8'h00
// control register bit positions
`define TMR_B_TF1 3'h7
`define TMR_B_TR1 3'h6
`define TMR_B_TF0 3'h5
`define TMR_B_TR0 3'h4
`define TMR_B_IE1 3'h3
`define TMR_B_IT1 3'h2
`define TMR_B_IE0 3'h1
`define TMR_B_IT0 3'h0
// mode select register bit positions
`define TMR_M_GATE1 3'h7
`define TMR_M_CT1 3'h6
`define TMR_M_MODE1_HI 3'h5
`define TMR_M_MODE1_LO 3'h4
`define TMR_M_GATE0 3'h3
`define TMR_M_CT0 3'h2
`define TMR_M_MODE0_HI 3'h1
`define TMR_M_MODE0_LO 3'h0
// mode codes
`define TMR_MODE_13BIT 2'h0
`define TMR_MODE_16BIT 2'h1
`define TMR_MODE_RELOAD 2'h2
`define TMR_MODE_SPLIT 2'h3
// counter limits
`define TMR_PRE_MSB 3'h4
`define TMR_PRE_MAX 5'h1f
`define TMR_PRE_ONE 5'h01
`define TMR_BYTE_MAX 8'hff
`define TMR_BYTE_ONE 8'h01
`endif

/* File: src/tmr_pin_sync.sv */
// pin synchroniser with falling edge detect
`timescale 1ns/1ps
module tmr_pin_sync #(
    parameter int STAGES = 2
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // asynchronous pin
    input wire logic pin_i,
    // synchronised level and edge
    output logic level_o,
    output logic fall_o
);
    logic [STAGES-1:0] sync_q;
    logic prev_q;

    generate
        if (STAGES < 2) begin : g_chk
            $error("tmr_pin_sync needs at least two stages");
        end
    endgenerate

    // pins idle high, so reset to one to avoid a false edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_q <= {STAGES{1'b1}};
            prev_q <= 1'b1;
        end else begin
            sync_q <= {sync_q[STAGES-2:0], pin_i};
            prev_q <= sync_q[STAGES-1];
        end
    end

    // high in one sample, low in the next
    assign level_o = sync_q[STAGES-1];
    assign fall_o = prev_q & ~sync_q[STAGES-1];
endmodule

/* File: src/tmr_pkg.sv */
// types and shared helper of the timer block
package tmr_pkg;
    typedef logic [7:0] tmr_byte_t;
    typedef logic [1:0] tmr_mode_t;

    // count enable: run bit and, when gated, the pin must be high
    function automatic logic tmr_cnt_en(input logic run, input logic gate, input logic pin_hi);
        return run & (~gate | pin_hi);
    endfunction
endpackage

/* File: src/tmr_timer01_ctrl.sv */
// timer 0/1 control register, count bytes and external interrupt flags
//
// Operation
// R1: timer 1 overflow sets bit 7; vectoring to its routine clears it.
// R2: timer 0 overflow sets bit 5; vectoring to its routine clears it.
// R3: bit 6 is timer 1 run control, one on, zero off.
// R4: bit 4 is timer 0 run control, one on, zero off.
// R5: bit 3 set by interrupt-1 pin falling edge or low level, per type.
// R6: bit 1 set by interrupt-0 pin falling edge or low level, per type.
// R7: edge flags clear on vectoring; level flags follow the pin instead.
// R8: bit 2 picks interrupt-1 trigger: one falling edge, zero low level.
// R9: bit 0 picks interrupt-0 trigger: one falling edge, zero low level.
// R10: the four low control bits never affect the timers.
// R11: each timer holds high and low bytes, split or joined per mode.
// R12: all four count bytes read zero after reset.
// R13: control register resets to zero and supports single bit writes.
// R14: both timers share mode behaviour unless a mode says otherwise.
// R15: no divide-by-twelve prescaler; every source event counts once.
// R16: modes: 13-bit, 16-bit, 8-bit reload, and stop or split.
// R17: count only with run set and gate clear or its pin high.
// R18: timer counts each clock; counter counts sampled input falls.
// R19: 13-bit mode uses high byte and five low bits; run keeps count.
// R20: software byte write beats increment; hardware flag set beats clear.
`timescale 1ns/1ps
`include "tmr_defs.svh"
module tmr_timer01_ctrl
    import tmr_pkg::*;
#(
    parameter int SYNC_STAGES = 2
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // special function register byte port
    input wire tmr_byte_t sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire tmr_byte_t sfr_wdata_i,
    input wire logic sfr_rd_i,
    output tmr_byte_t sfr_rdata_o,
    // bit operations on the control register
    input wire logic sfr_bit_wr_i,
    input wire logic [2:0] sfr_bit_sel_i,
    input wire logic sfr_bit_val_i,
    // mode select register held outside
    input wire tmr_byte_t timer_mode_select_reg_i,
    // vector acknowledges from the core
    input wire logic t0_vector_ack_i,
    input wire logic t1_vector_ack_i,
    input wire logic ext_irq0_vector_ack_i,
    input wire logic ext_irq1_vector_ack_i,
    // external pins
    input wire logic ext_irq0_pin_n_i,
    input wire logic ext_irq1_pin_n_i,
    input wire logic t0_count_input_i,
    input wire logic t1_count_input_i,
    // status towards interrupt controller and serial port
    output tmr_byte_t timer_ctrl_irq_flags_o,
    output logic t1_overflow_pulse_o
);
    tmr_byte_t ctrl_q, wr_mask, wr_val, sw_ctrl;
    tmr_byte_t t0_lo, t0_hi, t1_lo, t1_hi;
    tmr_byte_t rdata_q;
    logic t1_pulse_q;
    logic ext_irq0_pin_n_lvl, ext_irq0_pin_n_fall, ext_irq1_pin_n_lvl, ext_irq1_pin_n_fall;
    logic t0_in_lvl, t0_in_fall, t1_in_lvl, t1_in_fall;
    tmr_mode_t mode0, mode1;
    logic gate0, gate1, ct0, ct1, split0;
    logic t0_src, t1_src, t1_run;
    logic t0_lo_inc, t0_hi_inc, t1_lo_inc;
    logic t0_lo_ovf, t0_hi_ovf, t1_lo_ovf, t1_hi_ovf;
    logic tf0_set, tf1_set;
    logic ctrl_byte_wr;
    logic t0_lo_wr, t0_hi_wr, t1_lo_wr, t1_hi_wr;

    generate
        if (SYNC_STAGES < 2) begin : g_chk
            $error("tmr_timer01_ctrl needs at least two sync stages");
        end
    endgenerate

    // byte write decode, used for every register
    function automatic logic byte_wr(input logic wr, input tmr_byte_t addr, input tmr_byte_t target);
        return wr && (addr == target);
    endfunction

    // pin synchronisers; every pin is asynchronous to the core clock
    tmr_pin_sync #(.STAGES(SYNC_STAGES)) u_sync_irq0 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(ext_irq0_pin_n_i),
        .level_o(ext_irq0_pin_n_lvl),
        .fall_o(ext_irq0_pin_n_fall)
    );
    tmr_pin_sync #(.STAGES(SYNC_STAGES)) u_sync_irq1 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(ext_irq1_pin_n_i),
        .level_o(ext_irq1_pin_n_lvl),
        .fall_o(ext_irq1_pin_n_fall)
    );
    tmr_pin_sync #(.STAGES(SYNC_STAGES)) u_sync_cnt0 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(t0_count_input_i),
        .level_o(t0_in_lvl),
        .fall_o(t0_in_fall)
    );
    tmr_pin_sync #(.STAGES(SYNC_STAGES)) u_sync_cnt1 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(t1_count_input_i),
        .level_o(t1_in_lvl),
        .fall_o(t1_in_fall)
    );

    // mode select fields
    assign mode0 = timer_mode_select_reg_i[`TMR_M_MODE0_HI:`TMR_M_MODE0_LO];
    assign mode1 = timer_mode_select_reg_i[`TMR_M_MODE1_HI:`TMR_M_MODE1_LO];
    assign gate0 = timer_mode_select_reg_i[`TMR_M_GATE0];
    assign gate1 = timer_mode_select_reg_i[`TMR_M_GATE1];
    assign ct0 = timer_mode_select_reg_i[`TMR_M_CT0];
    assign ct1 = timer_mode_select_reg_i[`TMR_M_CT1];
    assign split0 = (mode0 == `TMR_MODE_SPLIT);

    // count sources: a clock in timer mode, a sampled fall in counter mode
    assign t0_src = ct0 ? t0_in_fall : 1'b1; // R18 R15
    assign t1_src = ct1 ? t1_in_fall : 1'b1; // R18 R15

    // timer 1 gives its run bit to the split high byte
    assign t1_run = split0 ? 1'b1 : ctrl_q[`TMR_B_TR1]; // R16

    // enables; the trigger and irq flag bits take no part here
    assign t0_lo_inc = tmr_cnt_en(ctrl_q[`TMR_B_TR0], gate0, ext_irq0_pin_n_lvl) & t0_src; // R4 R17 R10
    assign t0_hi_inc = split0 & ctrl_q[`TMR_B_TR1]; // R16 R3
    assign t1_lo_inc = (mode1 != `TMR_MODE_SPLIT) // R16 R14
        & tmr_cnt_en(t1_run, gate1, ext_irq1_pin_n_lvl) & t1_src; // R3 R17

    // count byte write strobes
    assign t0_lo_wr = byte_wr(sfr_wr_i, sfr_addr_i, `TMR_ADDR_T0_LO);
    assign t0_hi_wr = byte_wr(sfr_wr_i, sfr_addr_i, `TMR_ADDR_T0_HI);
    assign t1_lo_wr = byte_wr(sfr_wr_i, sfr_addr_i, `TMR_ADDR_T1_LO);
    assign t1_hi_wr = byte_wr(sfr_wr_i, sfr_addr_i, `TMR_ADDR_T1_HI);
    assign ctrl_byte_wr = byte_wr(sfr_wr_i, sfr_addr_i, `TMR_ADDR_CTRL);

    // timer 0 unit, the one that can split
    tmr_count_unit u_timer0 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .mode_i(mode0),
        .lo_inc_i(t0_lo_inc),
        .hi_inc_i(t0_hi_inc),
        .lo_wr_i(t0_lo_wr),
        .hi_wr_i(t0_hi_wr),
        .wdata_i(sfr_wdata_i),
        .lo_o(t0_lo),
        .hi_o(t0_hi),
        .lo_ovf_o(t0_lo_ovf),
        .hi_ovf_o(t0_hi_ovf)
    );

    // timer 1 unit; in its own split mode it simply holds
    tmr_count_unit u_timer1 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .mode_i(mode1),
        .lo_inc_i(t1_lo_inc),
        .hi_inc_i(1'b0),
        .lo_wr_i(t1_lo_wr),
        .hi_wr_i(t1_hi_wr),
        .wdata_i(sfr_wdata_i),
        .lo_o(t1_lo),
        .hi_o(t1_hi),
        .lo_ovf_o(t1_lo_ovf),
        .hi_ovf_o(t1_hi_ovf)
    );

    // overflow sources; the split high byte owns the timer 1 flag
    assign tf0_set = t0_lo_ovf; // R2
    assign tf1_set = split0 ? t0_hi_ovf : t1_lo_ovf; // R1 R16

    // software view of the control byte: whole byte or one bit
    always_comb begin
        wr_mask = 8'h00;
        wr_val = sfr_wdata_i;
        if (ctrl_byte_wr) begin
            wr_mask = 8'hff;
        end else if (sfr_bit_wr_i) begin
            wr_mask[sfr_bit_sel_i] = 1'b1; // R13
            wr_val = {8{sfr_bit_val_i}};
        end
        sw_ctrl = (ctrl_q & ~wr_mask) | (wr_val & wr_mask);
    end

    // run and trigger bits are plain software state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q[`TMR_B_TR1] <= 1'b0; // R13
            ctrl_q[`TMR_B_TR0] <= 1'b0;
            ctrl_q[`TMR_B_IT1] <= 1'b0;
            ctrl_q[`TMR_B_IT0] <= 1'b0;
        end else begin
            ctrl_q[`TMR_B_TR1] <= sw_ctrl[`TMR_B_TR1]; // R3
            ctrl_q[`TMR_B_TR0] <= sw_ctrl[`TMR_B_TR0]; // R4
            ctrl_q[`TMR_B_IT1] <= sw_ctrl[`TMR_B_IT1]; // R8
            ctrl_q[`TMR_B_IT0] <= sw_ctrl[`TMR_B_IT0]; // R9
        end
    end

    // overflow flags: a new overflow beats vector clear and software clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q[`TMR_B_TF1] <= 1'b0;
            ctrl_q[`TMR_B_TF0] <= 1'b0;
        end else begin
            if (tf1_set) begin
                ctrl_q[`TMR_B_TF1] <= 1'b1; // R1 R20
            end else if (t1_vector_ack_i) begin
                ctrl_q[`TMR_B_TF1] <= 1'b0; // R1
            end else begin
                ctrl_q[`TMR_B_TF1] <= sw_ctrl[`TMR_B_TF1];
            end
            if (tf0_set) begin
                ctrl_q[`TMR_B_TF0] <= 1'b1; // R2 R20
            end else if (t0_vector_ack_i) begin
                ctrl_q[`TMR_B_TF0] <= 1'b0; // R2
            end else begin
                ctrl_q[`TMR_B_TF0] <= sw_ctrl[`TMR_B_TF0];
            end
        end
    end

    // external irq flags; in level mode the pin owns the flag and
    // software writes are lost, which is the price of following the source
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q[`TMR_B_IE1] <= 1'b0;
            ctrl_q[`TMR_B_IE0] <= 1'b0;
        end else begin
            if (!ctrl_q[`TMR_B_IT1]) begin
                ctrl_q[`TMR_B_IE1] <= ~ext_irq1_pin_n_lvl; // R5 R7 R8
            end else if (ext_irq1_pin_n_fall) begin
                ctrl_q[`TMR_B_IE1] <= 1'b1; // R5 R20
            end else if (ext_irq1_vector_ack_i) begin
                ctrl_q[`TMR_B_IE1] <= 1'b0; // R7
            end else begin
                ctrl_q[`TMR_B_IE1] <= sw_ctrl[`TMR_B_IE1];
            end
            if (!ctrl_q[`TMR_B_IT0]) begin
                ctrl_q[`TMR_B_IE0] <= ~ext_irq0_pin_n_lvl; // R6 R7 R9
            end else if (ext_irq0_pin_n_fall) begin
                ctrl_q[`TMR_B_IE0] <= 1'b1; // R6 R20
            end else if (ext_irq0_vector_ack_i) begin
                ctrl_q[`TMR_B_IE0] <= 1'b0; // R7
            end else begin
                ctrl_q[`TMR_B_IE0] <= sw_ctrl[`TMR_B_IE0];
            end
        end
    end

    // registered read port; unmapped addresses read zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_q <= `TMR_RDATA_NONE;
        end else if (sfr_rd_i) begin
            case (sfr_addr_i)
                `TMR_ADDR_CTRL: rdata_q <= ctrl_q;
                `TMR_ADDR_T0_LO: rdata_q <= t0_lo; // R11
                `TMR_ADDR_T0_HI: rdata_q <= t0_hi;
                `TMR_ADDR_T1_LO: rdata_q <= t1_lo;
                `TMR_ADDR_T1_HI: rdata_q <= t1_hi;
                default: rdata_q <= `TMR_RDATA_NONE;
            endcase
        end
    end

    // timer 1 overflow for a baud generator, even without its flag
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            t1_pulse_q <= 1'b0;
        end else begin
            t1_pulse_q <= t1_lo_ovf;
        end
    end

    assign sfr_rdata_o = rdata_q;
    assign timer_ctrl_irq_flags_o = ctrl_q;
    assign t1_overflow_pulse_o = t1_pulse_q;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_tf0_on_ovf: assert property (tf0_set |=> ctrl_q[`TMR_B_TF0]) // R2
        else $error("timer 0 overflow did not set its flag");
    a_tf1_on_ovf: assert property (tf1_set |=> ctrl_q[`TMR_B_TF1]) // R1
        else $error("timer 1 overflow did not set its flag");
    a_tf1_vec_clear: assert property ( // R1
        t1_vector_ack_i && !tf1_set |=> !ctrl_q[`TMR_B_TF1])
        else $error("vector did not clear timer 1 flag");
    a_tf0_vec_clear: assert property ( // R2
        t0_vector_ack_i && !tf0_set |=> !ctrl_q[`TMR_B_TF0])
        else $error("vector did not clear timer 0 flag");
    a_run_bit_wr: assert property ( // R3
        sfr_bit_wr_i && !ctrl_byte_wr && sfr_bit_sel_i == `TMR_B_TR1
        |=> ctrl_q[`TMR_B_TR1] == $past(sfr_bit_val_i))
        else $error("bit write missed timer 1 run bit");
    a_t0_run_gate: assert property ( // R4
        t0_lo_inc |-> ctrl_q[`TMR_B_TR0] && (!gate0 || ext_irq0_pin_n_lvl))
        else $error("timer 0 counted while disabled");
    a_irq1_edge_set: assert property ( // R5
        ctrl_q[`TMR_B_IT1] && ext_irq1_pin_n_fall |=> ctrl_q[`TMR_B_IE1])
        else $error("falling edge did not set irq 1 flag");
    a_irq0_level: assert property ( // R7
        !ctrl_q[`TMR_B_IT0] |=> ctrl_q[`TMR_B_IE0] == !$past(ext_irq0_pin_n_lvl))
        else $error("level irq 0 flag did not follow pin");
    a_cnt_wr_wins: assert property ( // R20
        t0_lo_wr |=> t0_lo == $past(sfr_wdata_i))
        else $error("count write lost to increment");
    a_t1_hold_split: assert property ( // R16
        mode1 == `TMR_MODE_SPLIT && !t1_lo_wr && !t1_hi_wr |=> $stable(t1_lo) && $stable(t1_hi))
        else $error("timer 1 moved in its stop mode");
    a_reset_clear: assert property ( // R12
        $past(rst_i) |-> ctrl_q == `TMR_CTRL_RST && t0_lo == `TMR_CNT_RST && t1_hi == `TMR_CNT_RST)
        else $error("registers not zero after reset");
    a_timer_rate: assert property ( // R18
        mode0 == `TMR_MODE_16BIT && !ct0 && !gate0 && ctrl_q[`TMR_B_TR0] && !t0_lo_wr && !t0_hi_wr
        |=> {t0_hi, t0_lo} == 16'($past({t0_hi, t0_lo}) + 16'h0001))
        else $error("timer mode did not count every clock");
    // a whole-byte write must reach the run bits, not only single bit writes
    a_ctrl_byte_wr: assert property ( // R13
        ctrl_byte_wr |=> ctrl_q[`TMR_B_TR1] == $past(sfr_wdata_i[`TMR_B_TR1])
            && ctrl_q[`TMR_B_TR0] == $past(sfr_wdata_i[`TMR_B_TR0]))
        else $error("byte write missed the run bits");
    a_irq0_vec_clear: assert property ( // R7
        ctrl_q[`TMR_B_IT0] && ext_irq0_vector_ack_i && !ext_irq0_pin_n_fall |=> !ctrl_q[`TMR_B_IE0])
        else $error("vector did not clear edge irq 0 flag");

    c_t0_overflow: cover property (tf0_set);
    c_irq0_edge: cover property (ctrl_q[`TMR_B_IT0] && ext_irq0_pin_n_fall);
    c_split_tf1: cover property (split0 && t0_hi_ovf);
    c_counter_step: cover property (ct1 && t1_lo_inc);
    c_set_beats_clear: cover property (tf1_set && ctrl_byte_wr);
endmodule

/* File: verification/tb.sv */
// self-checking bench for the timer 0/1 control block
`timescale 1ns/1ps
`include "tmr_defs.svh"
module tb
    import tmr_pkg::*;
;
    logic clk_i;
    logic rst_i;
    tmr_byte_t sfr_addr_i, sfr_wdata_i, sfr_rdata_o, tmode, flags, lo;
    logic sfr_wr_i, sfr_rd_i, bwr, bval, ovp, p0, p1, c0, c1;
    logic [2:0] bsel;
    logic [3:0] acks;
    logic [16:0] s;
    logic [31:0] lfsr = 32'h0f0af627;
    tmr_byte_t q[$];
    logic rd_p = 1'b0;
    int err_count = 0;
    int compares = 0;
    int cyc = 0;
    int ovf1 = 0;

    tmr_timer01_ctrl u_tmr_timer01_ctrl (.clk_i(clk_i), .rst_i(rst_i), .sfr_addr_i(sfr_addr_i),
        .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rd_i(sfr_rd_i), .sfr_rdata_o(sfr_rdata_o),
        .sfr_bit_wr_i(bwr), .sfr_bit_sel_i(bsel), .sfr_bit_val_i(bval), .timer_mode_select_reg_i(tmode),
        .t0_vector_ack_i(acks[0]), .t1_vector_ack_i(acks[1]), .ext_irq0_vector_ack_i(acks[2]),
        .ext_irq1_vector_ack_i(acks[3]), .ext_irq0_pin_n_i(p0), .ext_irq1_pin_n_i(p1),
        .t0_count_input_i(c0), .t1_count_input_i(c1), .timer_ctrl_irq_flags_o(flags),
        .t1_overflow_pulse_o(ovp));
    tmr_pin_model u_tmr_pin_model (.clk_i(clk_i), .irq0_n_o(p0), .irq1_n_o(p1), .cnt0_o(c0), .cnt1_o(c1));

    // 50 MHz core clock
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    task automatic close_out();
        if (err_count == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input tmr_byte_t e, input tmr_byte_t g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %0t exp %h got %h", $time, e, g);
        end
    endtask

    // byte write, strobe held for exactly one taking edge
    task automatic wr(input tmr_byte_t a, input tmr_byte_t d);
        @(posedge clk_i);
        #1;
        sfr_addr_i = a;
        sfr_wdata_i = d;
        sfr_wr_i = 1'b1;
        @(posedge clk_i);
        #1;
        sfr_wr_i = 1'b0;
    endtask

    // read request, expected value noted for the monitor
    task automatic rd(input tmr_byte_t a, input tmr_byte_t e);
        @(posedge clk_i);
        #1;
        sfr_addr_i = a;
        sfr_rd_i = 1'b1;
        q.push_back(e);
        @(posedge clk_i);
        #1;
        sfr_rd_i = 1'b0;
    endtask

    task automatic bit_wr(input int b, input logic v);
        @(posedge clk_i);
        #1;
        bsel = 3'(b);
        bval = v;
        bwr = 1'b1;
        @(posedge clk_i);
        #1;
        bwr = 1'b0;
    endtask

    // k: 0 timer 0, 1 timer 1, 2 irq 0, 3 irq 1
    task automatic ack(input int k);
        @(posedge clk_i);
        #1;
        acks = 4'h1 << k;
        @(posedge clk_i);
        #1;
        acks = 4'h0;
    endtask

    // load, start, wait n, stop: the run bit stands for n + 2 edges
    task automatic run(input int t, input tmr_byte_t md, input tmr_byte_t l, input tmr_byte_t h, input int n);
        tmode = md;
        wr(`TMR_ADDR_T0_LO + 8'(t), l);
        wr(`TMR_ADDR_T0_HI + 8'(t), h);
        bit_wr(4 + 2 * t, 1'b1);
        repeat (n) @(posedge clk_i);
        bit_wr(4 + 2 * t, 1'b0);
    endtask

    // settle on the falling edge, then compare one control bit
    task automatic see(input int b, input logic v);
        @(negedge clk_i);
        chk(8'(flags[b]), 8'(v));
    endtask

    // read data lands on the edge after the read, so look half a cycle later
    always @(posedge clk_i) rd_p <= sfr_rd_i;
    always @(negedge clk_i) begin
        if (rd_p) chk(q.pop_front(), sfr_rdata_o);
    end

    // overflow pulse count and hang limit
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (ovp === 1'b1) ovf1 <= ovf1 + 1;
        if (cyc == 5000) begin
            err_count++;
            close_out();
        end
    end

    initial begin
        {sfr_addr_i, sfr_wdata_i, tmode, sfr_wr_i, sfr_rd_i, bwr, bval, bsel, acks} = '0;
        rst_i = 1'b1;
        repeat (20) @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        for (int a = 8'h88; a <= 8'h8d; a++) rd(8'(a), 8'h00);
        // 16-bit timers from a random low byte, always crossing all ones
        for (int t = 0; t < 2; t++) begin
            lo = {3'h7, lfsr[4:0]};
            lfsr = nxt(lfsr);
            s = {1'b0, 8'hff, lo} + 17'h20;
            run(t, 8'h11, lo, 8'hff, 30);
            rd(`TMR_ADDR_T0_LO + 8'(t), s[7:0]);
            rd(`TMR_ADDR_T0_HI + 8'(t), s[15:8]);
            rd(`TMR_ADDR_CTRL, 8'h20 << (2 * t));
            ack(t);
            rd(`TMR_ADDR_CTRL, 8'h00);
        end
        chk(8'(ovf1), 8'h01);
        // 13-bit: low five bits carry into the high byte, upper three hold
        run(0, 8'h00, 8'hfe, 8'h00, 0);
        rd(`TMR_ADDR_T0_LO, 8'he0);
        rd(`TMR_ADDR_T0_HI, 8'h01);
        // 8-bit reload from the high byte
        run(0, 8'h02, 8'hfe, 8'h80, 2);
        rd(`TMR_ADDR_T0_LO, 8'h82);
        rd(`TMR_ADDR_T0_HI, 8'h80);
        rd(`TMR_ADDR_CTRL, 8'h20);
        ack(0);
        // gated counters: falls pass only while the request pin is high
        for (int t = 0; t < 2; t++) begin
            run(t, t ? 8'hd0 : 8'h0d, 8'h00, 8'h00, 0);
            bit_wr(4 + 2 * t, 1'b1);
            u_tmr_pin_model.pulse(t, 5, 2 + t);
            repeat (5) @(posedge clk_i);
            u_tmr_pin_model.set_irq(t, 1'b0);
            repeat (5) @(posedge clk_i);
            u_tmr_pin_model.pulse(t, 3, 2);
            repeat (5) @(posedge clk_i);
            u_tmr_pin_model.set_irq(t, 1'b1);
            bit_wr(4 + 2 * t, 1'b0);
            rd(`TMR_ADDR_T0_LO + 8'(t), 8'h05);
        end
        // level then edge detection on both request pins
        for (int k = 0; k < 2; k++) begin
            u_tmr_pin_model.set_irq(k, 1'b0);
            repeat (6) @(posedge clk_i);
            see(1 + 2 * k, 1'b1);
            ack(2 + k);
            see(1 + 2 * k, 1'b1);
            u_tmr_pin_model.set_irq(k, 1'b1);
            repeat (6) @(posedge clk_i);
            see(1 + 2 * k, 1'b0);
            bit_wr(2 * k, 1'b1);
            u_tmr_pin_model.set_irq(k, 1'b0);
            repeat (3) @(posedge clk_i);
            u_tmr_pin_model.set_irq(k, 1'b1);
            repeat (6) @(posedge clk_i);
            rd(`TMR_ADDR_CTRL, 8'h03 << (2 * k));
            ack(2 + k);
            see(1 + 2 * k, 1'b0);
            bit_wr(2 * k, 1'b0);
        end
        // split timer 0 under both run bits; the stopping byte write meets the high byte wrap
        tmode = 8'h33;
        wr(`TMR_ADDR_T0_LO, 8'h10);
        wr(`TMR_ADDR_T0_HI, 8'hf8);
        wr(`TMR_ADDR_T1_LO, 8'h5a);
        wr(`TMR_ADDR_CTRL, 8'h50);
        repeat (6) @(posedge clk_i);
        wr(`TMR_ADDR_CTRL, 8'h00);
        rd(`TMR_ADDR_T0_LO, 8'h18);
        rd(`TMR_ADDR_T0_HI, 8'h00);
        rd(`TMR_ADDR_T1_LO, 8'h5a);
        rd(`TMR_ADDR_CTRL, 8'h80);
        chk(8'(ovf1), 8'h01);
        repeat (3) @(posedge clk_i);
        close_out();
    end
endmodule

/* File: verification/tmr_pin_model.sv */
// pin-side model: interrupt request pins and event count inputs
`timescale 1ns/1ps
module tmr_pin_model (
    // clock
    input wire logic clk_i,
    // pins towards the block
    output logic irq0_n_o,
    output logic irq1_n_o,
    output logic cnt0_o,
    output logic cnt1_o
);
    // all pins idle high so no false edge follows reset
    initial begin
        irq0_n_o = 1'b1;
        irq1_n_o = 1'b1;
        cnt0_o = 1'b1;
        cnt1_o = 1'b1;
    end
    // requester keeps its low level until it removes it itself
    task automatic set_irq(input int idx, input logic lvl);
        @(posedge clk_i);
        #1;
        if (idx == 0) irq0_n_o = lvl; else irq1_n_o = lvl;
    endtask
    // each level held at least one full clock, longer when slow
    task automatic pulse(input int idx, input int n, input int hold);
        repeat (2 * n) begin
            repeat (hold) @(posedge clk_i);
            #1;
            if (idx == 0) cnt0_o = ~cnt0_o; else cnt1_o = ~cnt1_o;
        end
    endtask
endmodule
